// ===== common/vwmi_regs.svh
// register offsets, field positions, reset values and codes of the memory interface
`ifndef VWMI_REGS_SVH
`define VWMI_REGS_SVH

// ==========================================
// offsets (byte addresses)
`define VWMI_OFF_STATUS 12'h000
`define VWMI_OFF_BANK_A 12'h004
`define VWMI_OFF_BANK_B 12'h008
`define VWMI_OFF_SPLIT 12'h00c
`define VWMI_OFF_ENGINE 12'h010

// ==========================================
// processor_status fields
`define VWMI_ST_FETCH_W_BIT 15
`define VWMI_ST_TRIG_BIT 14
`define VWMI_ST_RESET 32'h0000_0000
`define VWMI_ST_RW_MASK 32'h0000_7fff

// ==========================================
// bank control: [1:0] item size, [3:2] memory width, [7:4] wait states
`define VWMI_CFG_RST_W16 8'h06
`define VWMI_CFG_RST_W32 8'h0a
`define VWMI_SPLIT_RESET 24'h80_0000
`define VWMI_ENG_CNT_LSB 4

// ==========================================
// size and width codes (log2 of bytes)
`define VWMI_W8 2'h0
`define VWMI_W16 2'h1
`define VWMI_W32 2'h2

`endif

// ===== common/vwmi_pkg.sv
// types shared by the variable width memory interface
package vwmi_pkg;

  // ==========================================
  // engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BEAT = 3'b010,
    ST_PUSH = 3'b100
  } vwmi_state_t;

  // ==========================================
  // request from the core side; addr is a byte address
  typedef struct packed {
    logic write;
    logic fetch;
    logic [25:0] addr;
    logic [31:0] wdata;
  } vwmi_req_t;

  // ==========================================
  // per bank control register
  typedef struct packed {
    logic [3:0] wait_states;
    logic [1:0] mem_width;
    logic [1:0] item_size;
  } vwmi_bank_cfg_t;

  // ==========================================
  // one beat on the memory pins
  typedef struct packed {
    logic [23:0] addr;
    logic [3:0] aux_n;
    logic [31:0] dout;
    logic we_n;
    logic dout_en_n;
    logic bank_b;
  } vwmi_pins_t;

endpackage : vwmi_pkg

// ===== hw/vwmi_fifo.sv
// read data fifo of the memory interface
`timescale 1ns/1ps
`default_nettype none

module vwmi_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // fill level
  output logic [$clog2(DEPTH):0] count
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  assign count = cnt_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ==========================================
  // pointers
  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
    end
    if (pop) begin
      rd_next = (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + (PW+1)'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - (PW+1)'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

endmodule : vwmi_fifo

`default_nettype wire

// ===== hw/vwmi_top.sv
// variable width external memory interface with apb control registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

`include "vwmi_regs.svh"

module vwmi_top #(
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap
  input wire logic program_width_select,
  // core request
  input wire logic req_valid,
  input wire vwmi_pkg::vwmi_req_t req,
  output logic req_ready,
  // read data
  output logic resp_valid,
  output logic [31:0] resp_data,
  input wire logic resp_ready,
  // memory pins
  output logic [23:0] mem_addr,
  output logic [31:0] mem_dout,
  output logic mem_dout_en_n,
  input wire logic [31:0] mem_din,
  output logic mem_we_n,
  output logic [3:0] bank_a_strobe_n,
  output logic [3:0] bank_b_strobe_n
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  // ==========================================
  // register state
  logic [31:0] status_reg, status_next;
  vwmi_pkg::vwmi_bank_cfg_t cfg_a_reg, cfg_a_next, cfg_b_reg, cfg_b_next;
  logic [23:0] split_reg, split_next;
  vwmi_pkg::vwmi_state_t st_reg, st_next;
  vwmi_pkg::vwmi_req_t req_reg, req_next;
  logic [1:0] beat_reg, beat_next;
  logic [3:0] wait_reg, wait_next;
  logic [31:0] rd_reg, rd_next;
  vwmi_pkg::vwmi_pins_t pins_reg, pins_next;

  logic fifo_in_ready;
  logic [CW-1:0] fifo_count;
  logic apb_wr, apb_rd;

  // ==========================================
  // decode helpers
  function automatic logic hits_bank_b(input logic [25:0] a, input logic [23:0] split);
    hits_bank_b = (a[25:2] >= split);
  endfunction : hits_bank_b

  function automatic logic [1:0] legal(input logic [1:0] c);
    legal = (c == 2'h3) ? `VWMI_W32 : c;
  endfunction : legal

  function automatic logic [1:0] eff_size(input vwmi_pkg::vwmi_req_t r,
                                          input vwmi_pkg::vwmi_bank_cfg_t c);
    eff_size = r.fetch ? `VWMI_W32 : legal(c.item_size);
  endfunction : eff_size

  function automatic logic [1:0] eff_width(input vwmi_pkg::vwmi_req_t r,
                                           input vwmi_pkg::vwmi_bank_cfg_t c,
                                           input logic pw16);
    if (r.fetch) begin
      eff_width = pw16 ? `VWMI_W16 : `VWMI_W32;
    end else begin
      eff_width = legal(c.mem_width);
    end
  endfunction : eff_width

  // last beat index: 0, 1 or 3
  function automatic logic [1:0] last_beat(input logic [1:0] s, input logic [1:0] w);
    logic [1:0] n;
    n = (s > w) ? s - w : 2'h0;
    last_beat = (n == 2'h2) ? 2'h3 : n;
  endfunction : last_beat

  // byte address of a given beat
  function automatic logic [25:0] beat_addr(input logic [25:0] a, input logic [1:0] b,
                                            input logic [1:0] w);
    beat_addr = a + (26'(b) << w);
  endfunction : beat_addr

  // lane shift in bits for a byte address inside a memory word
  function automatic logic [4:0] lane_sh(input logic [25:0] ba, input logic [1:0] w);
    unique case (w)
      `VWMI_W8: lane_sh = 5'h0;
      `VWMI_W16: lane_sh = {1'b0, ba[0], 3'h0};
      default: lane_sh = {ba[1:0], 3'h0};
    endcase
  endfunction : lane_sh

  function automatic logic [31:0] bits_mask(input logic [1:0] c);
    unique case (c)
      `VWMI_W8: bits_mask = 32'h0000_00ff;
      `VWMI_W16: bits_mask = 32'h0000_ffff;
      default: bits_mask = 32'hffff_ffff;
    endcase
  endfunction : bits_mask

  // pin image of one beat
  function automatic vwmi_pkg::vwmi_pins_t beat_pins(input vwmi_pkg::vwmi_req_t r,
                                                     input logic [1:0] b,
                                                     input vwmi_pkg::vwmi_bank_cfg_t c,
                                                     input logic bb,
                                                     input logic pw16);
    vwmi_pkg::vwmi_pins_t p;
    logic [1:0] s, w;
    logic [25:0] ba;
    logic [5:0] chunk_sh;
    s = eff_size(r, c);
    w = eff_width(r, c, pw16);
    ba = beat_addr(r.addr, b, w);
    // three-bit sum: a 16-bit memory steps by 16, a shift of 4 that two bits would wrap
    chunk_sh = 6'(b) << (3'(w) + 3'h3);
    p.addr = ba[25:2];
    p.bank_b = bb;
    p.we_n = ~(r.write && !r.fetch);
    p.dout_en_n = ~(r.write && !r.fetch);
    p.dout = (r.wdata >> chunk_sh) << lane_sh(ba, w);
    unique case (w)
      `VWMI_W8: p.aux_n = {ba[1:0], 2'b10};
      `VWMI_W16: begin
        p.aux_n = {ba[1], 1'b1, 2'b00};
        if (s == `VWMI_W8) begin
          p.aux_n[1:0] = ba[0] ? 2'b01 : 2'b10;
        end
      end
      default: begin
        unique case (s)
          `VWMI_W8: p.aux_n = ~(4'b0001 << ba[1:0]);
          `VWMI_W16: p.aux_n = ba[1] ? 4'b0011 : 4'b1100;
          default: p.aux_n = 4'b0000;
        endcase
      end
    endcase
    beat_pins = p;
  endfunction : beat_pins

  localparam vwmi_pkg::vwmi_pins_t PINS_IDLE = '{
    addr: 24'h00_0000, aux_n: 4'hf, dout: 32'h0000_0000,
    we_n: 1'b1, dout_en_n: 1'b1, bank_b: 1'b0};

  // ==========================================
  // apb register file
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;

  always_comb begin
    status_next = status_reg;
    cfg_a_next = cfg_a_reg;
    cfg_b_next = cfg_b_reg;
    split_next = split_reg;
    if (apb_wr) begin
      unique case (paddr)
        `VWMI_OFF_STATUS: status_next = pwdata & `VWMI_ST_RW_MASK;
        `VWMI_OFF_BANK_A: cfg_a_next = pwdata[7:0];
        `VWMI_OFF_BANK_B: cfg_b_next = pwdata[7:0];
        `VWMI_OFF_SPLIT: split_next = pwdata[23:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (apb_rd || apb_wr) begin
      unique case (paddr)
        `VWMI_OFF_STATUS: begin
          prdata = status_reg;
          prdata[`VWMI_ST_FETCH_W_BIT] = program_width_select;
        end
        `VWMI_OFF_BANK_A: prdata = {24'h00_0000, cfg_a_reg};
        `VWMI_OFF_BANK_B: prdata = {24'h00_0000, cfg_b_reg};
        `VWMI_OFF_SPLIT: prdata = {8'h00, split_reg};
        `VWMI_OFF_ENGINE: begin
          prdata[0] = (st_reg != vwmi_pkg::ST_IDLE);
          prdata[`VWMI_ENG_CNT_LSB +: CW] = fifo_count;
        end
        default: pslverr = psel && penable;
      endcase
    end
  end

  // sync reset may sample the strap: it is a clocked load, not an async one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_reg <= `VWMI_ST_RESET;
      cfg_a_reg <= program_width_select ? `VWMI_CFG_RST_W16 : `VWMI_CFG_RST_W32;
      cfg_b_reg <= program_width_select ? `VWMI_CFG_RST_W16 : `VWMI_CFG_RST_W32;
      split_reg <= `VWMI_SPLIT_RESET;
    end else begin
      status_reg <= status_next;
      cfg_a_reg <= cfg_a_next;
      cfg_b_reg <= cfg_b_next;
      split_reg <= split_next;
    end
  end

  // ==========================================
  // access engine
  logic in_bank_b, cur_bank_b;
  vwmi_pkg::vwmi_bank_cfg_t in_cfg, cur_cfg;
  logic [1:0] cur_s, cur_w, cur_last;
  logic [25:0] cur_ba;
  logic [31:0] chunk;

  assign in_bank_b = hits_bank_b(req.addr, split_reg);
  assign in_cfg = in_bank_b ? cfg_b_reg : cfg_a_reg;
  assign cur_bank_b = hits_bank_b(req_reg.addr, split_reg);
  assign cur_cfg = cur_bank_b ? cfg_b_reg : cfg_a_reg;
  assign cur_s = eff_size(req_reg, cur_cfg);
  assign cur_w = eff_width(req_reg, cur_cfg, program_width_select);
  assign cur_last = last_beat(cur_s, cur_w);
  assign cur_ba = beat_addr(req_reg.addr, beat_reg, cur_w);
  // narrower of item and memory decides how many bits a beat brings
  assign chunk = ((mem_din >> lane_sh(cur_ba, cur_w)) &
                  bits_mask((cur_s < cur_w) ? cur_s : cur_w))
                 << (6'(beat_reg) << (3'(cur_w) + 3'h3));

  // a read is only taken when the fifo can hold its answer, except a fetch that also has write set
  assign req_ready = (st_reg == vwmi_pkg::ST_IDLE) && (req.write || fifo_in_ready);

  always_comb begin
    st_next = st_reg;
    req_next = req_reg;
    beat_next = beat_reg;
    wait_next = wait_reg;
    rd_next = rd_reg;
    pins_next = PINS_IDLE;
    unique case (st_reg)
      vwmi_pkg::ST_IDLE: begin
        if (req_valid && req_ready) begin
          req_next = req;
          beat_next = 2'h0;
          wait_next = in_cfg.wait_states;
          rd_next = 32'h0000_0000;
          st_next = vwmi_pkg::ST_BEAT;
          pins_next = beat_pins(req, 2'h0, in_cfg, in_bank_b, program_width_select);
        end
      end
      vwmi_pkg::ST_BEAT: begin
        pins_next = pins_reg;
        if (wait_reg != 4'h0) begin
          wait_next = wait_reg - 4'h1;
        end else begin
          rd_next = rd_reg | chunk;
          if (beat_reg == cur_last) begin
            pins_next = PINS_IDLE;
            st_next = (req_reg.write && !req_reg.fetch) ? vwmi_pkg::ST_IDLE
                                                        : vwmi_pkg::ST_PUSH;
          end else begin
            beat_next = beat_reg + 2'h1;
            wait_next = cur_cfg.wait_states;
            pins_next = beat_pins(req_reg, beat_reg + 2'h1, cur_cfg, cur_bank_b,
                                  program_width_select);
          end
        end
      end
      vwmi_pkg::ST_PUSH: begin
        if (fifo_in_ready) begin
          st_next = vwmi_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= vwmi_pkg::ST_IDLE;
      req_reg <= '0;
      beat_reg <= 2'h0;
      wait_reg <= 4'h0;
      rd_reg <= 32'h0000_0000;
      pins_reg <= PINS_IDLE;
    end else begin
      st_reg <= st_next;
      req_reg <= req_next;
      beat_reg <= beat_next;
      wait_reg <= wait_next;
      rd_reg <= rd_next;
      pins_reg <= pins_next;
    end
  end

  // ==========================================
  // pins
  assign mem_addr = pins_reg.addr;
  assign mem_dout = pins_reg.dout;
  assign mem_dout_en_n = pins_reg.dout_en_n;
  assign mem_we_n = pins_reg.we_n;
  assign bank_a_strobe_n = pins_reg.bank_b ? 4'hf : pins_reg.aux_n;
  assign bank_b_strobe_n = pins_reg.bank_b ? pins_reg.aux_n : 4'hf;

  // ==========================================
  // read data fifo
  vwmi_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(st_reg == vwmi_pkg::ST_PUSH),
    .in_data(rd_reg),
    .in_ready(fifo_in_ready),
    .out_valid(resp_valid),
    .out_data(resp_data),
    .out_ready(resp_ready),
    .count(fifo_count)
  );

endmodule : vwmi_top

`default_nettype wire

// ===== verification/vwmi_top_asserts.sv
// assertions on the ports of the variable width memory interface
`timescale 1ns/1ps
`default_nettype none

module vwmi_top_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  // core side
  input wire logic program_width_select,
  input wire logic req_valid,
  input wire vwmi_pkg::vwmi_req_t req,
  input wire logic req_ready,
  // memory pins
  input wire logic mem_we_n,
  input wire logic mem_dout_en_n,
  input wire logic [3:0] bank_a_strobe_n,
  input wire logic [3:0] bank_b_strobe_n
);
  logic acc;
  logic [3:0] aux;

  assign acc = req_valid && req_ready;
  // idle bank sits at all ones, so the and shows the live bank
  assign aux = bank_a_strobe_n & bank_b_strobe_n;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ==========================================
  // bank choice
  a_one_bank: assert property (
    (bank_a_strobe_n == 4'hf) || (bank_b_strobe_n == 4'hf))
    else $error("both banks strobed");
  a_bank_upper: assert property (
    acc && req.addr[25] |=> bank_a_strobe_n == 4'hf && bank_b_strobe_n != 4'hf)
    else $error("upper address missed bank b");
  a_bank_lower: assert property (
    acc && !req.addr[25] |=> bank_b_strobe_n == 4'hf && bank_a_strobe_n != 4'hf)
    else $error("lower address missed bank a");

  // ==========================================
  // instruction fetch, zero wait states assumed
  a_fetch_half: assert property (
    acc && req.fetch && program_width_select |=>
      aux == 4'h4 ##1 aux == 4'hc ##1 aux == 4'hf)
    else $error("half width fetch beats wrong");
  a_fetch_word: assert property (
    acc && req.fetch && !program_width_select |=> aux == 4'h0 ##1 aux == 4'hf)
    else $error("full width fetch beats wrong");

  // ==========================================
  // status view and bus direction
  a_status_view: assert property (
    psel && penable && !pwrite && paddr == 12'h000 |->
      prdata[15] == program_width_select && prdata[31:16] == 16'h0)
    else $error("status width bit wrong");
  a_read_quiet: assert property (
    acc && !req.write |=> mem_we_n && mem_dout_en_n)
    else $error("read drove the bus");
  a_write_drive: assert property (
    acc && req.write |=> !mem_we_n && !mem_dout_en_n)
    else $error("write did not drive the bus");
endmodule : vwmi_top_asserts

bind vwmi_top vwmi_top_asserts u_asserts (
  .ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .prdata,
  .program_width_select, .req_valid, .req, .req_ready,
  .mem_we_n, .mem_dout_en_n, .bank_a_strobe_n, .bank_b_strobe_n
);

`default_nettype wire

// ===== verification/vwmi_mem_model.sv
// static memory behind the interface pins, byte addressed
`timescale 1ns/1ps
`default_nettype none

module vwmi_mem_model (
  // clock
  input wire logic ref_clk,
  // memory pins
  input wire logic [23:0] mem_addr,
  input wire logic [31:0] mem_dout,
  input wire logic mem_we_n,
  input wire logic [3:0] bank_a_strobe_n,
  input wire logic [3:0] bank_b_strobe_n,
  output logic [31:0] mem_din,
  // wiring width of the attached memory
  input wire logic [1:0] width
);
  logic [7:0] mem [logic [25:0]];
  logic [31:0] last = 32'h0;
  logic [3:0] aux;
  logic [25:0] ba;

  function automatic logic [7:0] rb(input logic [25:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'ha5);
  endfunction : rb

  // ==========================================
  // read lanes; narrow parts repeat on every lane
  always_comb begin
    aux = bank_a_strobe_n & bank_b_strobe_n;
    ba = {mem_addr, 2'b00};
    if (width == 2'h1) ba[1] = aux[3];
    if (width == 2'h0) ba[1:0] = aux[3:2];
    // released bus shows garbage, never the old word
    if (aux == 4'hf) mem_din = ~last;
    else if (width == 2'h2) mem_din = {rb(ba + 26'd3), rb(ba + 26'd2), rb(ba + 26'd1), rb(ba)};
    else if (width == 2'h1) mem_din = {2{rb(ba + 26'd1), rb(ba)}};
    else mem_din = {4{rb(ba)}};
  end

  // ==========================================
  // writes only modelled on full width parts
  always @(posedge ref_clk) begin
    last <= mem_din;
    if (!mem_we_n && width == 2'h2) begin
      for (int i = 0; i < 4; i++) begin
        if (!aux[i]) mem[ba + 26'(i)] = mem_dout[8*i+:8];
      end
    end
  end
endmodule : vwmi_mem_model

`default_nettype wire

// ===== verification/vwmi_top_tb_top.sv
// self-checking bench of the variable width memory interface
`timescale 1ns/1ps
`default_nettype none

`include "vwmi_regs.svh"

module vwmi_top_tb_top;
  // ==========================================
  // signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr = 12'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, resp_data, mem_dout, mem_din, rd;
  logic pready, pslverr, req_ready, resp_valid, mem_dout_en_n, mem_we_n, perr;
  logic pws = 1'b1;
  logic req_valid = 1'b0;
  logic resp_ready = 1'b0;
  vwmi_pkg::vwmi_req_t req = '0;
  logic [23:0] mem_addr;
  logic [3:0] sa_n, sb_n;
  logic [1:0] mw = 2'h1;
  logic [25:0] a;
  logic [31:0] d;
  logic [7:0] wr [logic [25:0]];
  logic [31:0] expq [$];
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 32'h3abb7776;

  vwmi_top #(.FIFO_DEPTH(16)) uut (
    .ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .program_width_select(pws), .req_valid, .req, .req_ready, .resp_valid,
    .resp_data, .resp_ready, .mem_addr, .mem_dout, .mem_dout_en_n, .mem_din, .mem_we_n,
    .bank_a_strobe_n(sa_n), .bank_b_strobe_n(sb_n)
  );
  vwmi_mem_model u_mem (
    .ref_clk, .mem_addr, .mem_dout, .mem_we_n, .bank_a_strobe_n(sa_n),
    .bank_b_strobe_n(sb_n), .mem_din, .width(mw)
  );

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ==========================================
  // helpers
  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  function automatic logic [7:0] mb(input logic [25:0] x);
    return wr.exists(x) ? wr[x] : (x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'ha5);
  endfunction : mb

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cfg(input logic [1:0] s, input logic [1:0] w);
    apb(1'b1, `VWMI_OFF_BANK_A, {28'h0, w, s});
    apb(1'b1, `VWMI_OFF_BANK_B, {28'h0, w, s});
    mw <= w;
  endtask : cfg

  // one request; counts beats and notes which bank answered
  task automatic op(input logic w, input logic f, input logic [25:0] ad,
                    input logic [31:0] wd, input int nby, input int beats);
    logic [31:0] v;
    int nb;
    logic hb;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{w, f, ad, wd};
    do @(posedge ref_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    v = 32'h0;
    for (int i = 0; i < nby; i++) begin
      if (w) wr[ad + 26'(i)] = wd[8*i+:8];
      else v[8*i+:8] = mb(ad + 26'(i));
    end
    if (!w) expq.push_back(v);
    nb = 0;
    hb = 1'b0;
    do begin
      @(posedge ref_clk);
      if ((sa_n & sb_n) != 4'hf) nb++;
      if (sb_n != 4'hf) hb = 1'b1;
    end while ((sa_n & sb_n) != 4'hf);
    cmp(32'(nb), 32'(beats));
    cmp({31'h0, hb}, {31'h0, ad[25]});
  endtask : op

  task automatic drain();
    resp_ready <= 1'b1;
    while (expq.size() > 0) begin
      @(posedge ref_clk);
      if (resp_valid === 1'b1) cmp(resp_data, expq.pop_front());
    end
    resp_ready <= 1'b0;
  endtask : drain

  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, `VWMI_OFF_BANK_A, 32'h0);
    cmp(rd, 32'h6);
    apb(1'b0, `VWMI_OFF_STATUS, 32'h0);
    cmp(rd, 32'h8000);
    pws <= 1'b0;
    apb(1'b1, `VWMI_OFF_STATUS, 32'hffff_ffff);
    apb(1'b0, `VWMI_OFF_STATUS, 32'h0);
    cmp(rd, 32'h7fff);
    apb(1'b0, 12'h020, 32'h0);
    cmp({rd[30:0], perr}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, `VWMI_OFF_BANK_A, 32'h0);
    cmp(rd, 32'ha);
    apb(1'b0, `VWMI_OFF_STATUS, 32'h0);
    cmp(rd, 32'h0);
    mw <= 2'h2;
    op(1'b0, 1'b1, 26'($random(seed)) & 26'h1fffffc, 32'h0, 4, 1);
    pws <= 1'b1;
    mw <= 2'h1;
    op(1'b0, 1'b1, 26'($random(seed)) & 26'h1fffffc, 32'h0, 4, 2);
    drain();
    // every size and width pair, far side stalled until the fifo refuses
    for (int k = 0; k < 16; k++) begin
      cfg(2'(k % 3), 2'((k / 3) % 3));
      a = 26'($random(seed)) & ~26'((1 << (k % 3)) - 1);
      op(1'b0, 1'b0, a, 32'h0, 1 << (k % 3),
         (k % 3) > ((k / 3) % 3) ? 1 << ((k % 3) - ((k / 3) % 3)) : 1);
    end
    @(posedge ref_clk);
    cmp({31'h0, req_ready}, 32'h0);
    drain();
    // byte store into full width memory, then word read back
    cfg(2'h0, 2'h2);
    apb(1'b0, `VWMI_OFF_BANK_B, 32'h0);
    cmp(rd, 32'h8);
    a = 26'($random(seed));
    d = $random(seed);
    op(1'b1, 1'b0, a, d, 1, 1);
    cfg(2'h2, 2'h2);
    op(1'b0, 1'b0, {a[25:2], 2'b00}, 32'h0, 4, 1);
    drain();
    give_verdict();
  end
endmodule : vwmi_top_tb_top

`default_nettype wire
